// file: indexed_ext_regs.svh
// Register map, field positions and command codes of the indexed
// extension-word decoder.
// Assumes byte addresses on an APB bus with 32-bit words.
`ifndef INDEXED_EXT_REGS_SVH
`define INDEXED_EXT_REGS_SVH

// Register byte offsets; REG_INDEX_BASE is the value of address bits 7:6 for the index registers
`define REG_EXT_WORD    8'h00
`define REG_BASE        8'h04
`define REG_BASE_DISP   8'h08
`define REG_OUTER_DISP  8'h0C
`define REG_COMMAND     8'h10
`define REG_STATUS      8'h14
`define REG_EA_RESULT   8'h18
`define REG_CAS_ADDR    8'h1C
`define REG_CAS_CMP     8'h20
`define REG_CAS_UPD     8'h24
`define REG_CAS_VALUE   8'h28
`define REG_INDEX_BASE  2'h1

// Command bits
`define CMD_EA_BIT      0
`define CMD_CAS_BIT     1
`define CMD_TRAP_FALSE_INSTR_BIT   2

// Status bits
`define ST_BUSY_BIT     0
`define ST_DONE_BIT     1
`define ST_RSVD_BIT     2
`define ST_NE_BIT       3
`define ST_TRAP_FALSE_INSTR_BIT    4

// Extension word fields
`define EXT_DA_BIT      15
`define EXT_REG_HI      14
`define EXT_REG_LO      12
`define EXT_WL_BIT      11
`define EXT_SCALE_HI    10
`define EXT_SCALE_LO    9
`define EXT_FULL_BIT    8
`define EXT_BS_BIT      7
`define EXT_IS_BIT      6
`define EXT_BD_HI       5
`define EXT_BD_LO       4
`define EXT_SEL_HI      2
`define EXT_SEL_LO      0

// Size codes shared by base and outer displacement
`define DISP_RSVD       2'h0
`define DISP_NULL       2'h1
`define DISP_WORD       2'h2
`define DISP_LONG       2'h3

`endif

// file: ext_decode_pkg.sv
// Types of the indexed extension-word decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package ext_decode_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_INDEX,
      ST_FETCH,
      ST_CAS_RD,
      ST_CAS_WR
   } ea_state_t;

endpackage

// file: index_regfile.sv
// Sixteen 32-bit index registers: data registers 0-7, address 8-15.
// Assumes one write port and one registered read port on one clock.
`timescale 1ns/100ps
`default_nettype none
module index_regfile
   import ext_decode_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        reset_n_in,
   input  wire logic        wr_en_in,
   input  wire logic [3:0]  wr_addr_in,
   input  wire logic [31:0] wr_data_in,
   input  wire logic [3:0]  rd_addr_in,
   output logic      [31:0] rd_data_out
);

   logic [31:0] mem_r [0:15];

   // Array has no reset; software loads it before use
   always_ff @(posedge mclk_in) begin
      if (wr_en_in) begin
         mem_r[wr_addr_in] <= wr_data_in;
      end
   end

   // Registered read, one cycle after the address
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_data_out <= 32'h0000_0000;
      end else begin
         rd_data_out <= mem_r[rd_addr_in];
      end
   end

endmodule
`default_nettype wire

// file: ext_word_fields.sv
// Splits an extension word into its fields and flags reserved codes.
// Assumes a stable extension word; purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "indexed_ext_regs.svh"
module ext_word_fields
   import ext_decode_pkg::*;
(
   input  wire logic [15:0] ext_in,
   output logic      [3:0]  idx_num_out,
   output logic             idx_long_out,
   output logic      [1:0]  scale_out,
   output logic             full_fmt_out,
   output logic             base_suppress_flag_out,
   output logic             index_suppress_flag_out,
   output logic      [1:0]  base_disp_size_out,
   output logic      [2:0]  index_indirect_sel_out,
   output logic             indirect_out,
   output logic             post_index_out,
   output logic             reserved_out
);

   wire logic sel_hi;
   wire logic sel_lo_zero;

   // Index type bit joins the register number: 0-7 data, 8-15 address
   assign idx_num_out  = {ext_in[`EXT_DA_BIT],
                          ext_in[`EXT_REG_HI:`EXT_REG_LO]};
   assign idx_long_out = ext_in[`EXT_WL_BIT];
   assign scale_out    = ext_in[`EXT_SCALE_HI:`EXT_SCALE_LO];
   assign full_fmt_out = ext_in[`EXT_FULL_BIT];

   // Brief format carries none of the full-format controls except the base size field, which passes ungated
   assign base_suppress_flag_out  = full_fmt_out & ext_in[`EXT_BS_BIT];
   assign index_suppress_flag_out = full_fmt_out & ext_in[`EXT_IS_BIT];
   assign base_disp_size_out      = ext_in[`EXT_BD_HI:`EXT_BD_LO];
   assign index_indirect_sel_out  = full_fmt_out ?
                                    ext_in[`EXT_SEL_HI:`EXT_SEL_LO] : 3'h0;

   assign sel_hi      = index_indirect_sel_out[2];
   assign sel_lo_zero = (index_indirect_sel_out[1:0] == 2'h0);

   // Selection 000 means no memory indirection
   assign indirect_out   = (index_indirect_sel_out != 3'h0);
   // Indirect before indexing only with the index enabled
   assign post_index_out = sel_hi & ~index_suppress_flag_out;

   // Reserved: 100 with index, 1xx suppressed, base size 00
   assign reserved_out = full_fmt_out &
      ((sel_hi & (index_suppress_flag_out | sel_lo_zero)) |
       (base_disp_size_out == `DISP_RSVD));

endmodule
`default_nettype wire

// file: indexed_ext_word_decode.sv
// Extension-word decoder and effective-address engine with an
// indivisible compare-and-swap sequencer and a trap-false no-op.
// Assumes an APB master for registers and a memory bus that holds
// other masters off while mem_lock_out is high.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "indexed_ext_regs.svh"

module indexed_ext_word_decode
   import ext_decode_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        reset_n_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic             pready_out,
   output logic      [31:0] prdata_out,
   output logic             pslverr_out,
   // Operand memory bus master
   output logic             mem_req_out,
   output logic             mem_we_out,
   output logic             mem_lock_out,
   output logic      [31:0] mem_addr_out,
   output logic      [31:0] mem_wdata_out,
   input  wire logic        mem_ack_in,
   input  wire logic [31:0] mem_rdata_in
);

   // Sign extension of a word, used for index and displacements
   function automatic logic [31:0] sext16(input logic [31:0] v);
      sext16 = {{16{v[15]}}, v[15:0]};
   endfunction

   // Picks the displacement value for a size code
   function automatic logic [31:0] disp_sel(input logic [1:0]  sz,
                                            input logic [31:0] v);
      case (sz)
         `DISP_WORD: disp_sel = sext16(v);
         `DISP_LONG: disp_sel = v;
         default:    disp_sel = 32'h0000_0000;
      endcase
   endfunction

   // Registers
   ea_state_t   state_r;
   ea_state_t   state_nxt;
   logic [15:0] ext_r;
   logic [31:0] base_r;
   logic [31:0] bd_r;
   logic [31:0] od_r;
   logic [31:0] ea_r;
   logic [31:0] ea_nxt;
   logic [31:0] cas_addr_r;
   logic [31:0] cas_cmp_r;
   logic [31:0] cas_upd_r;
   logic [31:0] cas_val_r;
   logic [31:0] mem_addr_r;
   logic [31:0] mem_addr_nxt;
   logic        done_r;
   logic        rsvd_r;
   logic        ne_r;
   logic        trap_false_instr_r;
   logic [31:0] prdata_r;
   logic        slverr_r;

   // Decoded fields
   wire logic [3:0]  idx_num;
   wire logic        idx_long;
   wire logic [1:0]  scale;
   wire logic        full_fmt;
   wire logic        base_suppress_flag;
   wire logic        index_suppress_flag;
   wire logic [1:0]  base_disp_size;
   wire logic [2:0]  index_indirect_sel;
   wire logic        indirect;
   wire logic        post_index;
   wire logic        reserved;
   wire logic [31:0] idx_raw;

   ext_word_fields u_fields (
      .ext_in                  (ext_r),
      .idx_num_out             (idx_num),
      .idx_long_out            (idx_long),
      .scale_out               (scale),
      .full_fmt_out            (full_fmt),
      .base_suppress_flag_out  (base_suppress_flag),
      .index_suppress_flag_out (index_suppress_flag),
      .base_disp_size_out      (base_disp_size),
      .index_indirect_sel_out  (index_indirect_sel),
      .indirect_out            (indirect),
      .post_index_out          (post_index),
      .reserved_out            (reserved)
   );

   // APB decode; zero wait states, so every access ends in one cycle
   wire logic       setup_ph = psel_in & ~penable_in;
   wire logic       wr_acc   = psel_in & penable_in & pwrite_in;
   wire logic       idx_hit  = (paddr_in[7:6] == `REG_INDEX_BASE);
   wire logic [7:0] pa       = {paddr_in[7:2], 2'h0};
   wire logic       mapped   = idx_hit | (pa <= `REG_CAS_VALUE);
   wire logic       wr_ok    = wr_acc & mapped;
   wire logic       wr_idx   = wr_acc & idx_hit;
   wire logic       busy     = (state_r != ST_IDLE);

   wire logic wr_cmd  = wr_ok & (pa == `REG_COMMAND);
   wire logic wr_stat = wr_ok & (pa == `REG_STATUS);
   // Operands other than the index registers stay frozen while the engine runs
   wire logic wr_oper = wr_ok & ~busy;

   // Commands while busy are dropped; lowest command bit wins
   wire logic go_ea    = wr_cmd & ~busy & pwdata_in[`CMD_EA_BIT];
   wire logic go_cas   = wr_cmd & ~busy & ~pwdata_in[`CMD_EA_BIT] &
                         pwdata_in[`CMD_CAS_BIT];
   wire logic go_trap_false_instr = wr_cmd & ~busy & ~pwdata_in[`CMD_EA_BIT] &
                         ~pwdata_in[`CMD_CAS_BIT] &
                         pwdata_in[`CMD_TRAP_FALSE_INSTR_BIT];

   index_regfile u_regs (
      .mclk_in     (mclk_in),
      .reset_n_in  (reset_n_in),
      .wr_en_in    (wr_idx),
      .wr_addr_in  (paddr_in[5:2]),
      .wr_data_in  (pwdata_in),
      .rd_addr_in  (idx_num),
      .rd_data_out (idx_raw)
   );

   // Address arithmetic
   wire logic [31:0] idx_val  = idx_long ? idx_raw : sext16(idx_raw);
   wire logic [31:0] idx_scl  = idx_val << scale;
   wire logic [31:0] idx_term = index_suppress_flag ?
                                32'h0000_0000 : idx_scl;
   wire logic [31:0] base_term = base_suppress_flag ?
                                 32'h0000_0000 : base_r;
   // Brief format: sign-extended 8-bit displacement in the low byte
   wire logic [31:0] bd_term = full_fmt ?
                               disp_sel(base_disp_size, bd_r) :
                               {{24{ext_r[7]}}, ext_r[7:0]};
   wire logic [31:0] od_term = disp_sel(index_indirect_sel[1:0], od_r);
   wire logic [31:0] base_bd = base_term + bd_term;
   // Indexing ahead of the fetch unless indirection comes first
   wire logic [31:0] pre_addr = post_index ? base_bd :
                                base_bd + idx_term;
   wire logic [31:0] fetch_ea = mem_rdata_in + od_term +
                                (post_index ? idx_term :
                                 32'h0000_0000);
   wire logic        cas_eq   = (mem_rdata_in == cas_cmp_r);

   // Sequencer
   always_comb begin
      state_nxt    = state_r;
      ea_nxt       = ea_r;
      mem_addr_nxt = mem_addr_r;
      case (state_r)
         ST_IDLE: begin
            if (go_ea) begin
               state_nxt = ST_INDEX;
            end else if (go_cas) begin
               state_nxt    = ST_CAS_RD;
               mem_addr_nxt = cas_addr_r;
            end
         end
         ST_INDEX: begin
            // Index register read lands here, one cycle after the start
            if (reserved) begin
               state_nxt = ST_IDLE;
            end else if (indirect) begin
               state_nxt    = ST_FETCH;
               mem_addr_nxt = pre_addr;
            end else begin
               state_nxt = ST_IDLE;
               ea_nxt    = pre_addr;
            end
         end
         ST_FETCH: begin
            if (mem_ack_in) begin
               state_nxt = ST_IDLE;
               ea_nxt    = fetch_ea;
            end
         end
         ST_CAS_RD: begin
            if (mem_ack_in) begin
               state_nxt = cas_eq ? ST_CAS_WR : ST_IDLE;
            end
         end
         ST_CAS_WR: begin
            if (mem_ack_in) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // Completion events
   wire logic ev_rsvd  = (state_r == ST_INDEX) & reserved;
   wire logic ev_ea    = ((state_r == ST_INDEX) & ~indirect) | ev_rsvd |
                         ((state_r == ST_FETCH) & mem_ack_in);
   wire logic ev_ne    = (state_r == ST_CAS_RD) & mem_ack_in & ~cas_eq;
   wire logic ev_cas   = ev_ne | ((state_r == ST_CAS_WR) & mem_ack_in);
   wire logic ev_done  = ev_ea | ev_cas | go_trap_false_instr;
   // Write-one-to-clear; a same-cycle event keeps the flag set
   wire logic clr_done  = wr_stat & pwdata_in[`ST_DONE_BIT];
   wire logic clr_rsvd  = wr_stat & pwdata_in[`ST_RSVD_BIT];
   wire logic clr_trap_false_instr = wr_stat & pwdata_in[`ST_TRAP_FALSE_INSTR_BIT];

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r    <= ST_IDLE;
         ea_r       <= 32'h0000_0000;
         mem_addr_r <= 32'h0000_0000;
      end else begin
         state_r    <= state_nxt;
         ea_r       <= ea_nxt;
         mem_addr_r <= mem_addr_nxt;
      end
   end

   // Status flags
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         done_r  <= 1'b0;
         rsvd_r  <= 1'b0;
         ne_r    <= 1'b0;
         trap_false_instr_r <= 1'b0;
      end else begin
         done_r  <= ev_done | (done_r & ~clr_done);
         rsvd_r  <= ev_rsvd | (rsvd_r & ~clr_rsvd);
         ne_r    <= ev_ne | (ne_r & ~go_cas);
         trap_false_instr_r <= go_trap_false_instr | (trap_false_instr_r & ~clr_trap_false_instr);
      end
   end

   // Value read by the swap, kept for the retry loop
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cas_val_r <= 32'h0000_0000;
      end else if ((state_r == ST_CAS_RD) & mem_ack_in) begin
         cas_val_r <= mem_rdata_in;
      end
   end

   // Software-written operands
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ext_r      <= 16'h0000;
         base_r     <= 32'h0000_0000;
         bd_r       <= 32'h0000_0000;
         od_r       <= 32'h0000_0000;
         cas_addr_r <= 32'h0000_0000;
         cas_cmp_r  <= 32'h0000_0000;
         cas_upd_r  <= 32'h0000_0000;
      end else if (wr_oper) begin
         case (pa)
            `REG_EXT_WORD:   ext_r      <= pwdata_in[15:0];
            `REG_BASE:       base_r     <= pwdata_in;
            `REG_BASE_DISP:  bd_r       <= pwdata_in;
            `REG_OUTER_DISP: od_r       <= pwdata_in;
            `REG_CAS_ADDR:   cas_addr_r <= pwdata_in;
            `REG_CAS_CMP:    cas_cmp_r  <= pwdata_in;
            `REG_CAS_UPD:    cas_upd_r  <= pwdata_in;
            default:         ext_r      <= ext_r;
         endcase
      end
   end

   // Read mux; index registers are write-only and read as zero
   logic [31:0] rd_mux;
   always_comb begin
      case (pa)
         `REG_EXT_WORD:   rd_mux = {16'h0000, ext_r};
         `REG_BASE:       rd_mux = base_r;
         `REG_BASE_DISP:  rd_mux = bd_r;
         `REG_OUTER_DISP: rd_mux = od_r;
         `REG_STATUS:     rd_mux = {27'h0000000, trap_false_instr_r, ne_r, rsvd_r,
                                    done_r, busy};
         `REG_EA_RESULT:  rd_mux = ea_r;
         `REG_CAS_ADDR:   rd_mux = cas_addr_r;
         `REG_CAS_CMP:    rd_mux = cas_cmp_r;
         `REG_CAS_UPD:    rd_mux = cas_upd_r;
         `REG_CAS_VALUE:  rd_mux = cas_val_r;
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data and error are caught in the setup cycle
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         prdata_r <= 32'h0000_0000;
         slverr_r <= 1'b0;
      end else if (setup_ph) begin
         prdata_r <= (pwrite_in | idx_hit) ? 32'h0000_0000 : rd_mux;
         slverr_r <= ~mapped;
      end
   end

   assign pready_out  = 1'b1;
   assign prdata_out  = prdata_r;
   assign pslverr_out = slverr_r;

   // Lock spans read and write so no interrupt or master splits them
   assign mem_req_out   = (state_r == ST_FETCH) | (state_r == ST_CAS_RD) |
                          (state_r == ST_CAS_WR);
   assign mem_lock_out  = (state_r == ST_CAS_RD) |
                          (state_r == ST_CAS_WR);
   assign mem_we_out    = (state_r == ST_CAS_WR);
   assign mem_addr_out  = mem_addr_r;
   assign mem_wdata_out = cas_upd_r;

endmodule
`default_nettype wire

// file: ext_decode_asserts.sv
// Port checker for the extension-word decoder.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
`include "indexed_ext_regs.svh"
module ext_decode_asserts (
   input wire logic        mclk_in,
   input wire logic        reset_n_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic        pready_out,
   input wire logic [31:0] prdata_out,
   input wire logic        pslverr_out,
   input wire logic        mem_req_out,
   input wire logic        mem_we_out,
   input wire logic        mem_lock_out,
   input wire logic [31:0] mem_addr_out,
   input wire logic [31:0] mem_wdata_out,
   input wire logic        mem_ack_in,
   input wire logic [31:0] mem_rdata_in
);
   logic [31:0] upd_r;
   logic [31:0] addr_r;
   wire         acc_w = psel_in && penable_in && pwrite_in;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   // Shadow of the swap operands; frozen while a swap holds the lock
   always_ff @(posedge mclk_in) begin
      if (acc_w && !mem_lock_out && paddr_in == `REG_CAS_UPD)
         upd_r <= pwdata_in;
      if (acc_w && !mem_lock_out && paddr_in == `REG_CAS_ADDR)
         addr_r <= pwdata_in;
   end
   // Command accepted while the memory side is quiet
   sequence s_cmd(logic [2:0] code);
      acc_w && paddr_in == `REG_COMMAND && pwdata_in[2:0] == code
      && !mem_req_out;
   endsequence
   sequence s_lock_rd;
      mem_req_out && mem_lock_out && !mem_we_out && mem_ack_in;
   endsequence
   a_cas_lock_start: assert property (s_cmd(3'h2) |=>
      mem_req_out && mem_lock_out && !mem_we_out)
      else $error("no locked read");
   a_write_locked: assert property (mem_we_out |->
      mem_lock_out && mem_req_out) else $error("unlocked write");
   a_read_first: assert property ($rose(mem_we_out) |->
      $past(mem_lock_out) && $past(mem_ack_in))
      else $error("write not after read");
   a_write_releases: assert property (mem_we_out && mem_ack_in |=>
      !mem_req_out && !mem_lock_out) else $error("lock kept after write");
   a_lock_holds: assert property (s_lock_rd ##1 mem_lock_out |->
      mem_we_out && mem_req_out) else $error("lock without write");
   a_req_steady: assert property (mem_req_out && !mem_ack_in |=>
      mem_req_out && $stable(mem_addr_out)) else $error("request dropped");
   a_swap_data: assert property (mem_we_out |->
      mem_wdata_out == upd_r && mem_addr_out == addr_r)
      else $error("bad swap write");
   a_trap_false_instr_quiet: assert property (s_cmd(3'h4) |=>
      !mem_req_out [*4]) else $error("trap-false touched memory");
   a_ea_read_only: assert property (mem_req_out && !mem_lock_out |->
      !mem_we_out) else $error("address fetch wrote");
endmodule
bind indexed_ext_word_decode ext_decode_asserts i_ext_decode_asserts (
   .mclk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
   .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .mem_req_out,
   .mem_we_out, .mem_lock_out, .mem_addr_out, .mem_wdata_out,
   .mem_ack_in, .mem_rdata_in);
`default_nettype wire

// file: operand_mem_model.sv
// Operand memory and arbiter model on the far side of the decoder.
// Assumes a level request held until a one-cycle ack.
`timescale 1ns/100ps
`default_nettype none
module operand_mem_model (
   input  wire logic        mclk_in,
   input  wire logic        reset_n_in,
   input  wire logic        slow_in,
   input  wire logic        bump_in,
   input  wire logic        mem_req_in,
   input  wire logic        mem_we_in,
   input  wire logic        mem_lock_in,
   input  wire logic [31:0] mem_addr_in,
   input  wire logic [31:0] mem_wdata_in,
   output logic             mem_ack_out,
   output logic      [31:0] mem_rdata_out
);
   logic [31:0] mem_r [16];
   logic [2:0]  wait_r;
   // Slow mode adds three wait cycles; data is garbled outside the ack
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mem_ack_out <= 1'b0;
         mem_rdata_out <= 32'h0;
         wait_r <= 3'h0;
         for (int i = 0; i < 16; i++)
            mem_r[i] <= 32'hA5C3_0000 | 32'(i * 36);
      end else if (mem_ack_out || !mem_req_in) begin
         mem_ack_out <= 1'b0;
         mem_rdata_out <= ~mem_rdata_out;
         // Another master only gets the bus while no lock is held
         if (bump_in && !mem_lock_in)
            mem_r[15] <= mem_r[15] + 32'h1;
      end else if (slow_in && wait_r != 3'h3) begin
         wait_r <= wait_r + 3'h1;
      end else begin
         wait_r <= 3'h0;
         mem_ack_out <= 1'b1;
         mem_rdata_out <= mem_r[mem_addr_in[5:2]];
         if (mem_we_in)
            mem_r[mem_addr_in[5:2]] <= mem_wdata_in;
      end
   end
endmodule
`default_nettype wire

// file: tb_indexed_ext_word_decode.sv
// Self-checking bench for the extension-word decoder.
// Assumes the APB slave and the memory model beside it.
`timescale 1ns/100ps
`default_nettype none
`include "indexed_ext_regs.svh"
module tb_indexed_ext_word_decode;
   logic        mclk_in, reset_n_in, psel_in, penable_in, pwrite_in;
   logic        pready_out, pslverr_out, slow, bump;
   logic        mem_req_out, mem_we_out, mem_lock_out, mem_ack_in;
   logic [7:0]  paddr_in;
   logic [31:0] pwdata_in, prdata_out, mem_addr_out, mem_wdata_out;
   logic [31:0] mem_rdata_in, rd_r;
   logic [15:0] lfsr_r;
   logic [31:0] regs_r [16];
   logic [32:0] exp_q [$];
   int          err_total, num_checks;
   indexed_ext_word_decode i_indexed_ext_word_decode (.mclk_in,
      .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .mem_req_out,
      .mem_we_out, .mem_lock_out, .mem_addr_out, .mem_wdata_out,
      .mem_ack_in, .mem_rdata_in);
   operand_mem_model i_mem (.mclk_in, .reset_n_in, .slow_in(slow),
      .bump_in(bump), .mem_req_in(mem_req_out), .mem_we_in(mem_we_out),
      .mem_lock_in(mem_lock_out), .mem_addr_in(mem_addr_out),
      .mem_wdata_in(mem_wdata_out), .mem_ack_out(mem_ack_in),
      .mem_rdata_out(mem_rdata_in));
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Each finished read with a note queued is held against the oldest note
   always @(posedge mclk_in)
      if (psel_in && penable_in && !pwrite_in && exp_q.size() > 0)
         check({pslverr_out, prdata_out}, exp_q.pop_front());
   function automatic logic [31:0] sx16(input logic [31:0] v);
      return {{16{v[15]}}, v[15:0]};
   endfunction
   function automatic logic [31:0] sized(input logic [1:0] s,
                                         input logic [31:0] v);
      return s == 2'h3 ? v : s == 2'h2 ? sx16(v) : 32'h0;
   endfunction
   // Maximal-length 16-bit sequence, so no value repeats early
   function automatic logic [15:0] lfsr_step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic rnd(output logic [31:0] v);
      lfsr_r = lfsr_step(lfsr_r);
      v[31:16] = lfsr_r;
      lfsr_r = lfsr_step(lfsr_r);
      v[15:0] = lfsr_r;
   endtask
   // One APB transfer; an edge first so no strobe is set twice at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge mclk_in);
      penable_in <= 1'b1;
      do @(posedge mclk_in); while (pready_out !== 1'b1);
      rd_r = prdata_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task automatic rd_exp(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   // Start a command and poll until done, then check and clear status
   task automatic run(input logic [2:0] cmd, input logic [31:0] st);
      int n;
      apb(1'b1, `REG_COMMAND, {29'h0, cmd});
      n = 0;
      do begin
         apb(1'b0, `REG_STATUS, 32'h0);
         n++;
      end while (rd_r[1] !== 1'b1 && n < 50);
      rd_exp(`REG_STATUS, {1'b0, st});
      apb(1'b1, `REG_STATUS, 32'h0000_0016);
   endtask
   task automatic report_and_stop();
      $display("Counts: %0d checks, %0d mismatches", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      #200000;
      err_total++;
      report_and_stop();
   end
   initial begin
      logic [31:0] v, bv, dv, ov, idx, pre, fa, ea, cmp;
      logic [15:0] ext;
      logic        rsv;
      {psel_in, penable_in, pwrite_in, slow, bump} = 5'h0;
      paddr_in = 8'h00;
      pwdata_in = 32'h0;
      reset_n_in = 1'b0;
      lfsr_r = 16'h0032;
      repeat (16) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      rd_exp(`REG_STATUS, 33'h0);
      rd_exp(8'h30, {1'b1, 32'h0});
      apb(1'b1, 8'h30, 32'hFFFF_FFFF);
      for (int i = 0; i < 16; i++) begin
         rnd(regs_r[i]);
         apb(1'b1, 8'h40 + 8'(i * 4), regs_r[i]);
      end
      rd_exp(8'h44, 33'h0);
      $display("Test registers done");
      // Every selection with and without index, then a reserved size
      for (int k = 0; k < 17; k++) begin
         rnd(v);
         rnd(bv);
         rnd(dv);
         rnd(ov);
         slow <= v[16];
         ext = {v[15:11], k[1:0], 1'b1, v[7], k[3], v[5:4], 1'b0, k[2:0]};
         if (k == 16)
            ext[5:4] = 2'h0;
         else if (ext[5:4] == 2'h0)
            ext[5:4] = 2'h3;
         rsv = ext[5:4] == 2'h0 || (ext[2] && (ext[6] || ext[1:0] == 2'h0));
         idx = regs_r[ext[15:12]];
         if (!ext[11])
            idx = sx16(idx);
         idx = ext[6] ? 32'h0 : idx << ext[10:9];
         pre = (ext[7] ? 32'h0 : bv) + sized(ext[5:4], dv);
         fa = pre + (ext[2] ? 32'h0 : idx);
         // A reserved code leaves the result register as it was
         if (!rsv && ext[2:0] == 3'h0)
            ea = pre + idx;
         else if (!rsv)
            ea = i_mem.mem_r[fa[5:2]] + sized(ext[1:0], ov)
               + (ext[2] ? idx : 32'h0);
         apb(1'b1, `REG_EXT_WORD, {16'h0, ext});
         apb(1'b1, `REG_BASE, bv);
         apb(1'b1, `REG_BASE_DISP, dv);
         apb(1'b1, `REG_OUTER_DISP, ov);
         run(3'h1, rsv ? 32'h6 : 32'h2);
         rd_exp(`REG_EA_RESULT, {1'b0, ea});
      end
      // Brief format: byte displacement, index always added
      idx = v[11] ? regs_r[v[15:12]] : sx16(regs_r[v[15:12]]);
      ea = bv + {{24{v[7]}}, v[7:0]} + (idx << v[10:9]);
      apb(1'b1, `REG_EXT_WORD, {16'h0, v[15:9], 1'b0, v[7:0]});
      run(3'h1, 32'h2);
      rd_exp(`REG_EA_RESULT, {1'b0, ea});
      $display("Test address modes done");
      run(3'h4, 32'h12);
      $display("Test trap-false done");
      cmp = i_mem.mem_r[5];
      rnd(v);
      apb(1'b1, `REG_CAS_ADDR, 32'h0000_0014);
      apb(1'b1, `REG_CAS_CMP, cmp);
      apb(1'b1, `REG_CAS_UPD, v);
      run(3'h2, 32'h2);
      check({1'b0, i_mem.mem_r[5]}, {1'b0, v});
      cmp = i_mem.mem_r[15];
      bump <= 1'b1;
      @(posedge mclk_in);
      bump <= 1'b0;
      apb(1'b1, `REG_CAS_ADDR, 32'h0000_003C);
      apb(1'b1, `REG_CAS_CMP, cmp);
      run(3'h2, 32'hA);
      rd_exp(`REG_CAS_VALUE, {1'b0, cmp + 32'h1});
      check({1'b0, i_mem.mem_r[15]}, {1'b0, cmp + 32'h1});
      $display("Test swap done");
      report_and_stop();
   end
endmodule
`default_nettype wire
